// file: logic/thermal_age_thresholds.sv
// Threshold register bank with thermal and aging flag logic on AHB-Lite
//
// What this block does
// R1 - Signed temperature limits, defaults FE0C and 1B58
// R2 - Warn when outside limits five seconds straight
// R3 - Sustained excursion sets thermal flag at 0x21
// R4 - Temperature limit write echoes OK, applies now
// R5 - Failure: error status, code, zero data, field
// R6 - Aging thresholds unsigned percent, zero to 100
// R7 - Out-of-range aging threshold rejected, range error code
// R8 - Age above fatal threshold sets fatal flag
// R9 - Age above warning threshold sets warning flag
// R10 - Aging threshold write echoes OK, applies now
// R11 - All four thresholds kept in saved storage
// R12 - Beginning of life 0x0000, end 0x0064
// R13 - Host keeps fatal threshold at 100 or less
// R14 - Host keeps warning between zero and fatal
// R15 - Laser age input compared against both thresholds
// R16 - Return inside limits restarts the timer
// R17 - Exceeded means strictly greater, unsigned
//
// Design decision made here: the AHB-Lite slave port.
`default_nettype none
module thermal_age_thresholds
   import thermal_age_pkg::*;
#(
   parameter logic [TIMER_W-1:0] PERSIST_CYCLES_P = TIMER_W'(PERSIST_CYCLES)
) (
   input  wire logic        hclk,                   // Bus clock, 40 MHz
   input  wire logic        hresetn,                // Async reset, active low
   input  wire logic        hsel,                   // Slave select
   input  wire logic [31:0] haddr,                  // Byte address
   input  wire logic [1:0]  htrans,                 // Transfer type
   input  wire logic        hwrite,                 // Write when high
   input  wire logic [2:0]  hsize,                  // Transfer size
   input  wire logic [31:0] hwdata,                 // Write data
   input  wire logic        hready,                 // Bus ready
   output var  logic [31:0] hrdata,                 // Read data
   output var  logic        hreadyout,              // Slave ready
   output var  logic        hresp,                  // Always OKAY
   input  wire logic [15:0] base_plate_temperature, // Signed, degC*100
   input  wire logic [15:0] laser_age_pct,          // Unsigned, percent
   output var  logic        thermal_warning_flag,   // Sticky thermal warning
   output var  logic        fatal_aging_flag,       // Sticky fatal aging
   output var  logic        warning_aging_flag,     // Sticky warning aging
   output var  logic        execution_error_status  // Last access failed
);

   // Data phase state
   logic                 dp_valid_reg;       // Data phase pending
   logic                 dp_write_reg;       // Pending is a write
   logic                 dp_legal_reg;       // Word access, low region
   logic [6:0]           dp_idx_reg;         // Register index
   logic                 hreadyout_reg;      // Wait state control
   logic [31:0]          hrdata_reg;         // Read data flop
   // Register storage
   logic [15:0]          thr_reg [NUM_THR];  // Live thresholds
   logic [15:0]          nv_reg  [NUM_THR];  // Saved thresholds
   logic [15:0]          fatal_status_reg;   // Fatal status
   logic [15:0]          warning_status_reg; // Warning status
   logic [31:0]          response_reg;       // Last response word
   logic [7:0]           error_field_reg;    // Last error code
   // Persistence timer
   persist_state_e       state_reg;          // Timer state
   persist_state_e       state_next;         // Next timer state
   logic [TIMER_W-1:0]   cnt_reg;            // Cycles outside
   logic [TIMER_W-1:0]   cnt_next;           // Next count
   // Decode results
   logic                 wr_now;             // Write executes
   logic                 rd_now;             // Read executes
   logic                 addr_take;          // Address phase taken
   logic [7:0]           acc_code;           // Access error code
   logic [31:0]          rd_data;            // Read mux
   logic                 track_resp;         // Access updates response
   logic                 out_of_range;       // Temperature outside
   logic                 fatal_cond;         // Age above fatal
   logic                 warn_cond;          // Age above warning
   logic                 nv_save;            // Save pulse
   logic                 nv_load;            // Load pulse
   logic [15:0]          wdata16;            // Low half of write data

   assign addr_take = hsel & htrans[1] & hready;
   assign wr_now    = dp_valid_reg & dp_write_reg;
   assign rd_now    = dp_valid_reg & ~dp_write_reg;
   assign wdata16   = hwdata[15:0];
   assign nv_save   = wr_now && (acc_code == ERR_NONE) && (dp_idx_reg == IDX_NV_CTRL)
                      && hwdata[NV_SAVE_BIT];
   assign nv_load   = wr_now && (acc_code == ERR_NONE) && (dp_idx_reg == IDX_NV_CTRL)
                      && hwdata[NV_LOAD_BIT];

   // Capture the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_legal_reg <= 1'b0;
         dp_idx_reg   <= 7'h00;
      end else begin
         dp_valid_reg <= addr_take;
         if (addr_take) begin
            dp_write_reg <= hwrite;
            dp_legal_reg <= (hsize == HSIZE_WORD) && (haddr[31:9] == 23'h000000)
                            && (haddr[1:0] == 2'b00);
            dp_idx_reg   <= haddr[8:2];
         end
      end
   end

   // Reads take one wait state so a write just before is visible
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_reg <= 1'b1;
         hrdata_reg    <= 32'h00000000;
      end else begin
         hreadyout_reg <= ~(addr_take & ~hwrite);
         if (rd_now) begin
            hrdata_reg <= rd_data;
         end
      end
   end

   assign hreadyout = hreadyout_reg;
   assign hrdata    = hrdata_reg;
   assign hresp     = 1'b0;

   // Read mux and access checking
   always_comb begin
      rd_data    = 32'h00000000;
      acc_code   = ERR_NONE;
      track_resp = 1'b1;
      case (dp_idx_reg)
         IDX_FATAL_STATUS: begin
            rd_data[15:0] = fatal_status_reg;
         end
         IDX_WARN_STATUS: begin
            rd_data[15:0] = warning_status_reg;
         end
         IDX_TEMP_LOW, IDX_TEMP_HIGH: begin
            rd_data[15:0] = thr_reg[2'(dp_idx_reg - IDX_TEMP_LOW)];
         end
         IDX_FATAL_AGE, IDX_WARN_AGE: begin
            rd_data[15:0] = thr_reg[2'(dp_idx_reg - IDX_TEMP_LOW)];
            // Beyond end of life is unusable
            if (dp_write_reg && (wdata16 > AGE_EOL)) begin
               acc_code = ERR_RANGE; // R7 R6 R12
            end
         end
         IDX_LASER_AGE: begin
            rd_data[15:0] = laser_age_pct;
            if (dp_write_reg) begin
               acc_code = ERR_READ_ONLY;
            end
         end
         IDX_NV_CTRL: begin
            rd_data = 32'h00000000; // Action bits read zero
         end
         IDX_RESPONSE: begin
            // Reading the response must not overwrite it
            rd_data    = response_reg;
            track_resp = 1'b0;
            if (dp_write_reg) begin
               acc_code = ERR_READ_ONLY;
            end
         end
         IDX_ERROR_FIELD: begin
            rd_data[7:0] = error_field_reg;
            track_resp   = 1'b0;
         end
         default: begin
            acc_code = ERR_NOT_IMPL;
         end
      endcase
      if (!dp_legal_reg) begin
         acc_code = ERR_NOT_IMPL;
         rd_data  = 32'h00000000;
      end
   end

   // Threshold storage, live and saved copy per entry
   genvar gi;
   generate
      for (gi = 0; gi < NUM_THR; gi++) begin : g_thr
         // Live value applies the cycle after a good write
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               thr_reg[gi] <= THR_RESET[gi]; // R1
            end else if (wr_now && (acc_code == ERR_NONE)
                         && (dp_idx_reg == IDX_TEMP_LOW + 7'(gi))) begin
               thr_reg[gi] <= wdata16; // R4 R10
            end else if (nv_load) begin
               thr_reg[gi] <= nv_reg[gi]; // R11
            end
         end
         // Saved copy, updated only by the save action
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               nv_reg[gi] <= THR_RESET[gi];
            end else if (nv_save) begin
               nv_reg[gi] <= thr_reg[gi]; // R11
            end
         end
      end
   endgenerate

   // Response word and error field
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         response_reg    <= 32'h00000000;
         error_field_reg <= ERR_NONE;
      end else if (dp_valid_reg) begin
         if (acc_code != ERR_NONE) begin
            // Failed access: zero data, error status
            response_reg <= {ERR_DATA, acc_code, 7'h00, STATUS_ERR}; // R5
            error_field_reg <= acc_code; // R5
         end else begin
            if (track_resp) begin
               if (dp_write_reg) begin
                  response_reg <= {wdata16, ERR_NONE, 7'h00, STATUS_OK}; // R4 R10
               end else begin
                  response_reg <= {rd_data[15:0], ERR_NONE, 7'h00, STATUS_OK};
               end
            end
            // A good write to the error field clears it; a failed one loads its error code
            if (dp_write_reg && (dp_idx_reg == IDX_ERROR_FIELD)) begin
               error_field_reg <= ERR_NONE;
            end
         end
      end
   end

   assign execution_error_status = response_reg[RESP_STAT_BIT];

   // Signed compare against both limits
   assign out_of_range = ($signed(base_plate_temperature) > $signed(thr_reg[1])) // R2
                      || ($signed(base_plate_temperature) < $signed(thr_reg[0])); // R2
   // Strictly greater, unsigned
   assign fatal_cond = laser_age_pct > thr_reg[2]; // R17 R15
   assign warn_cond  = laser_age_pct > thr_reg[3]; // R17 R15

   // Persistence timer next state
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ST_INSIDE: begin
            cnt_next = {TIMER_W{1'b0}};
            if (out_of_range) begin
               state_next = ST_OUTSIDE;
               cnt_next   = TIMER_W'(1);
            end
         end
         ST_OUTSIDE: begin
            if (!out_of_range) begin
               // Brief excursions leave no trace
               state_next = ST_INSIDE; // R16
               cnt_next   = {TIMER_W{1'b0}}; // R16
            end else if (cnt_reg >= PERSIST_CYCLES_P - TIMER_W'(1)) begin
               state_next = ST_WARN; // R2
            end else begin
               cnt_next = cnt_reg + TIMER_W'(1);
            end
         end
         ST_WARN: begin
            if (!out_of_range) begin
               state_next = ST_INSIDE;
               cnt_next   = {TIMER_W{1'b0}};
            end
         end
         default: begin
            state_next = ST_INSIDE;
            cnt_next   = {TIMER_W{1'b0}};
         end
      endcase
   end

   // Persistence timer state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_INSIDE;
         cnt_reg   <= {TIMER_W{1'b0}};
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Sticky status; set wins over write-one-to-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fatal_status_reg   <= 16'h0000;
         warning_status_reg <= 16'h0000;
      end else begin
         if (wr_now && dp_legal_reg && (dp_idx_reg == IDX_FATAL_STATUS)) begin
            fatal_status_reg <= fatal_status_reg & ~wdata16;
         end
         if (wr_now && dp_legal_reg && (dp_idx_reg == IDX_WARN_STATUS)) begin
            warning_status_reg <= warning_status_reg & ~wdata16;
         end
         if (fatal_cond) begin
            fatal_status_reg[FATAL_AGE_BIT] <= 1'b1; // R8
         end
         if (state_reg == ST_WARN) begin
            warning_status_reg[THERM_BIT] <= 1'b1; // R3
         end
         if (warn_cond) begin
            warning_status_reg[WARN_AGE_BIT] <= 1'b1; // R9
         end
      end
   end

   assign thermal_warning_flag = warning_status_reg[THERM_BIT];
   assign warning_aging_flag   = warning_status_reg[WARN_AGE_BIT];
   assign fatal_aging_flag     = fatal_status_reg[FATAL_AGE_BIT];

endmodule : thermal_age_thresholds
`default_nettype wire

// file: logic/thermal_age_pkg.sv
// Constants, register map and types of the threshold register bank
`default_nettype none
package thermal_age_pkg;
   // Register indices; byte address is four times the index
   localparam logic [6:0] IDX_FATAL_STATUS = 7'h20;
   localparam logic [6:0] IDX_WARN_STATUS  = 7'h21;
   localparam logic [6:0] IDX_TEMP_LOW     = 7'h5D;
   localparam logic [6:0] IDX_TEMP_HIGH    = 7'h5E;
   localparam logic [6:0] IDX_FATAL_AGE    = 7'h5F;
   localparam logic [6:0] IDX_WARN_AGE     = 7'h60;
   localparam logic [6:0] IDX_LASER_AGE    = 7'h61;
   localparam logic [6:0] IDX_NV_CTRL      = 7'h7C;
   localparam logic [6:0] IDX_RESPONSE     = 7'h7D;
   localparam logic [6:0] IDX_ERROR_FIELD  = 7'h7E;
   localparam int         NUM_THR          = 4;
   // Reset values: low, high, fatal age, warning age
   localparam logic [15:0] THR_RESET [NUM_THR] = '{16'hFE0C, 16'h1B58, 16'h0064, 16'h0050};
   localparam logic [15:0] AGE_BOL  = 16'h0000;
   localparam logic [15:0] AGE_EOL  = 16'h0064;
   localparam logic [15:0] ERR_DATA = 16'h0000;
   // Status bit positions
   localparam int FATAL_AGE_BIT = 0;
   localparam int THERM_BIT     = 0;
   localparam int WARN_AGE_BIT  = 1;
   localparam int NV_SAVE_BIT   = 0;
   localparam int NV_LOAD_BIT   = 1;
   // Response word layout
   localparam int   RESP_DATA_LSB = 16;
   localparam int   RESP_CODE_LSB = 8;
   localparam int   RESP_STAT_BIT = 0;
   localparam logic STATUS_OK     = 1'b0;
   localparam logic STATUS_ERR    = 1'b1;
   localparam logic [7:0] ERR_NONE      = 8'h00;
   localparam logic [7:0] ERR_RANGE     = 8'h01;
   localparam logic [7:0] ERR_READ_ONLY = 8'h02;
   localparam logic [7:0] ERR_NOT_IMPL  = 8'h03;
   localparam logic [2:0] HSIZE_WORD    = 3'b010;
   // Persistence time
   localparam longint CLK_HZ         = 40000000;
   localparam longint PERSIST_S      = 5;
   localparam longint PERSIST_CYCLES = CLK_HZ * PERSIST_S;
   localparam int     TIMER_W        = 28;
   // Persistence states, Gray along inside-outside-warn
   typedef enum logic [1:0] {
      ST_INSIDE  = 2'b00,
      ST_OUTSIDE = 2'b01,
      ST_WARN    = 2'b11
   } persist_state_e;
endpackage : thermal_age_pkg
`default_nettype wire

// file: verification/thermal_age_monitor.sv
// Bus timing, flag and error checks for the threshold register bank
`default_nettype none
module thermal_age_monitor
   import thermal_age_pkg::*;
(
   input wire logic        hclk,                  // Clock
   input wire logic        hresetn,               // Reset, active low
   input wire logic        hsel,                  // Select
   input wire logic [31:0] haddr,                 // Byte address
   input wire logic [1:0]  htrans,                // Transfer type
   input wire logic        hwrite,                // Direction
   input wire logic [2:0]  hsize,                 // Size
   input wire logic [31:0] hwdata,                // Write data
   input wire logic        hready,                // Bus ready
   input wire logic        hreadyout,             // Slave ready
   input wire logic        hresp,                 // Response
   input wire logic [15:0] laser_age_pct,         // Age input
   input wire logic        thermal_warning_flag,  // Thermal flag
   input wire logic        fatal_aging_flag,      // Fatal flag
   input wire logic        warning_aging_flag,    // Warning flag
   input wire logic        execution_error_status // Error bit
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       dp;      // Data phase open
   logic       dp_wr;   // Open phase is a write
   logic       dp_ok;   // Word size, clean address
   logic [6:0] dp_idx;  // Register index
   wire logic  take = hsel && htrans[1] && hready;
   wire logic  fin  = dp && hreadyout;
   wire logic  wfin = fin && dp_wr;
   wire logic  age_wr = wfin && dp_ok && (dp_idx == IDX_FATAL_AGE || dp_idx == IDX_WARN_AGE);
   wire logic  tmp_wr = wfin && dp_ok && (dp_idx == IDX_TEMP_LOW || dp_idx == IDX_TEMP_HIGH);
   // Track the one outstanding data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp <= 1'b0;
      end else if (take) begin
         dp <= 1'b1;
      end else if (hreadyout) begin
         dp <= 1'b0;
      end
   end
   // Address qualifiers, only read while dp is high so no reset needed
   always_ff @(posedge hclk) begin
      if (take) begin
         dp_wr  <= hwrite;
         dp_idx <= haddr[8:2];
         dp_ok  <= (haddr[31:9] == 23'h0) && (haddr[1:0] == 2'b00) && (hsize == HSIZE_WORD);
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_take_rd;
      take && !hwrite;
   endsequence
   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   chk_read_one_wait: assert property (s_take_rd |=> s_rd_answer)
      else $error("read data phase timing wrong");
   chk_write_no_wait: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   chk_bus_okay: assert property (hresp == 1'b0)
      else $error("bus response not OKAY");
   chk_fatal_age_set: assert property (laser_age_pct > AGE_EOL |=> fatal_aging_flag)
      else $error("fatal aging flag missing");
   chk_warn_age_set: assert property (laser_age_pct > AGE_EOL |=> warning_aging_flag)
      else $error("warning aging flag missing");
   chk_flag_clear_cause: assert property (($fell(thermal_warning_flag) || $fell(fatal_aging_flag)
      || $fell(warning_aging_flag)) |-> $past(wfin))
      else $error("status flag dropped without a write");
   chk_error_moment: assert property ($changed(execution_error_status) |-> $past(dp))
      else $error("error bit moved outside an access");
   chk_age_range: assert property (age_wr && hwdata[15:0] > AGE_EOL |=> execution_error_status)
      else $error("out of range age threshold accepted");
   chk_age_accept: assert property (age_wr && hwdata[15:0] <= AGE_EOL |=> !execution_error_status)
      else $error("legal age threshold refused");
   chk_temp_accept: assert property (tmp_wr |=> !execution_error_status)
      else $error("temperature limit write refused");
endmodule : thermal_age_monitor
bind thermal_age_thresholds thermal_age_monitor mon (.*);
`default_nettype wire

// file: verification/host_model.sv
// Host side bus master issuing single word register transfers
`default_nettype none
module host_model
   import thermal_age_pkg::*;
(
   input  wire logic        hclk,   // Clock
   input  wire logic        hready, // Bus ready
   input  wire logic [31:0] hrdata, // Read data
   output var  logic        hsel,   // Select
   output var  logic [31:0] haddr,  // Byte address
   output var  logic [1:0]  htrans, // Transfer type
   output var  logic        hwrite, // Direction
   output var  logic [2:0]  hsize,  // Size
   output var  logic [31:0] hwdata  // Write data
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus at time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = HSIZE_WORD;
      hwdata = 32'h0;
   end
   // One transfer; called right after a rising edge, returns at the answering edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= a;
      // No assumed latency; only the bench watchdog ends a hang
      do begin @(posedge hclk); end while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      haddr  <= ~a;
      hwdata <= d;
      do begin @(posedge hclk); end while (hready !== 1'b1);
      q = hrdata;
      // Released data must not look valid
      hwdata <= ~d;
   endtask : xfer
endmodule : host_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the threshold register bank
`default_nettype none
module tb_top
   import thermal_age_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Short persistence so the run stays brief
   localparam logic [TIMER_W-1:0] PC = TIMER_W'(16);
   logic hclk = 1'b0;                 // Bus clock
   logic hresetn = 1'b0;              // Reset, active low
   logic [15:0] temp = 16'h0000;      // Base plate temperature
   logic [15:0] age = 16'h0000;       // Laser age
   wire logic hsel, hwrite, hreadyout, hresp, tflag, fflag, wflag, err;
   logic [31:0] q_raw;                // Raw transfer result
   wire logic [31:0] haddr, hwdata, hrdata;
   wire logic [1:0] htrans;
   wire logic [2:0] hsize;
   int fail_count = 0;                // Mismatches
   int tests_run = 0;                 // Comparisons
   logic [15:0] av [4] = '{16'h0030, 16'h0031, 16'h0064, 16'h0065}; // Ages
   logic [1:0]  ex [4] = '{2'b00, 2'b10, 2'b10, 2'b11};             // Warn, fatal
   always #12.5 hclk = ~hclk;
   thermal_age_thresholds #(.PERSIST_CYCLES_P(PC)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .base_plate_temperature(temp), .laser_age_pct(age), .thermal_warning_flag(tflag),
      .fatal_aging_flag(fflag), .warning_aging_flag(wflag), .execution_error_status(err));
   host_model host (
      .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   task automatic tally_and_finish();
      if (fail_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   function automatic logic [31:0] ba(input logic [6:0] i);
      return {23'h0, i, 2'b00};
   endfunction : ba
   task automatic wr(input logic [6:0] i, input logic [15:0] d);
      logic [31:0] q;
      host.xfer(1'b1, ba(i), {16'h0000, d}, q);
   endtask : wr
   task automatic rd(input logic [6:0] i, input logic [31:0] e);
      logic [31:0] q;
      host.xfer(1'b0, ba(i), 32'h0, q);
      check(q, e);
   endtask : rd
   // Hold temperature for n cycles, then compare the thermal flag
   task automatic hold(input logic [15:0] t, input int n, input logic e);
      temp <= t;
      repeat (n) @(posedge hclk);
      check({31'h0, tflag}, {31'h0, e});
   endtask : hold
   // Hang guard, far beyond the few hundred cycles of the run
   initial begin
      #100us;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      for (int k = 0; k < NUM_THR; k++) rd(IDX_TEMP_LOW + 7'(k), {16'h0, THR_RESET[k]});
      wr(IDX_TEMP_HIGH, 16'h0100);
      rd(IDX_RESPONSE, {16'h0100, ERR_NONE, 8'h00});
      hold(16'h0101, 14, 1'b0);
      hold(16'h0100, 20, 1'b0);
      hold(16'h0101, 14, 1'b0);
      hold(16'h0101, 20, 1'b1);
      rd(IDX_WARN_STATUS, 32'h1);
      temp <= 16'h0000;
      wr(IDX_WARN_STATUS, 16'h0001);
      hold(16'hFF00, 24, 1'b0);
      hold(16'hFE0B, 20, 1'b1);
      wr(IDX_FATAL_AGE, 16'h0065);
      rd(IDX_RESPONSE, {16'h0, ERR_RANGE, 8'h01});
      rd(IDX_ERROR_FIELD, {24'h0, ERR_RANGE});
      rd(IDX_FATAL_AGE, {16'h0, AGE_EOL});
      wr(IDX_FATAL_AGE, AGE_EOL);
      rd(IDX_RESPONSE, {AGE_EOL, ERR_NONE, 8'h00});
      wr(IDX_WARN_AGE, 16'h0030);
      for (int k = 0; k < 4; k++) begin
         age <= av[k];
         repeat (3) @(posedge hclk);
         check({30'h0, wflag, fflag}, {30'h0, ex[k]});
      end
      rd(IDX_LASER_AGE, 32'h0065);
      rd(IDX_FATAL_STATUS, 32'h1);
      rd(IDX_WARN_STATUS, 32'h3);
      rd(7'h7F, 32'h0);
      rd(IDX_RESPONSE, {16'h0, ERR_NOT_IMPL, 8'h01});
      wr(IDX_LASER_AGE, 16'h0001);
      rd(IDX_RESPONSE, {16'h0, ERR_READ_ONLY, 8'h01});
      rd(IDX_ERROR_FIELD, {24'h0, ERR_READ_ONLY});
      // Misaligned read must fail and return zero
      host.xfer(1'b0, ba(IDX_TEMP_LOW) | 32'h1, 32'h0, q_raw);
      check(q_raw, 32'h0);
      rd(IDX_RESPONSE, {16'h0, ERR_NOT_IMPL, 8'h01});
      wr(IDX_ERROR_FIELD, 16'h0000);
      rd(IDX_ERROR_FIELD, 32'h0);
      wr(IDX_WARN_AGE, 16'h0010);
      wr(IDX_NV_CTRL, 16'h0001);
      wr(IDX_WARN_AGE, 16'h0020);
      wr(IDX_NV_CTRL, 16'h0002);
      rd(IDX_WARN_AGE, 32'h0010);
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rd(IDX_WARN_AGE, {16'h0, THR_RESET[3]});
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
